// ### pkg/ramp_pkg.sv
// Constants, register map and types for the segmented frequency ramp generator
// Functional notes
// - An active segment adds its increment to the numerator every step.
// - Upper limit is a numerator offset; one integer divider step is 2^24 units.
// - Lower limit is a 33-bit two's-complement numerator offset.
// - Each segment runs its step count; counts reach 65536 and no further.
// - Increment is added to the fractional numerator over a 2^24 denominator.
// - A zero increment holds frequency for the full count, a dwell segment.
// - A finished segment hands over to the index in its successor field.
// - Successor trigger 0 starts the next segment at once.
// - Successor trigger 2 waits for an event on the second trigger channel.
// - Numerator clear bit returns the numerator to zero before segment starts.
// - Source select 1 makes a rising first trigger pin an event.
// - Pin configuration 7 makes the pin an input to the trigger logic.
// - A segment naming itself as successor repeats forever; it is a sawtooth only with its clear bit set.
// - Keying deviation adds to the ramped carrier; both run independently.
// - One enable bit starts ramping; keying waits for its own trigger event, and disabling clears both.
// - Comparator flags rise at thresholds and can route to any of the three pins.
// - Comparator mask has one bit per segment; 3 covers segments zero and one.
// - Slow step bit applies the increment every second clock cycle.
// - Eight segments, each with own increment, count, successor, trigger, clear.
// - Trigger pins can output a flag marking each segment start.
// - Trigger select 1 chooses the first trigger channel.
// - Source select 3 makes a rising keying pin an event.
package ramp_pkg;
	localparam int DENOM_BITS = 24;
	localparam int NUM_W = 33;
	localparam int CNT_W = 16;
	localparam int SRC_W = 3;
	localparam int PINCFG_W = 4;
	localparam int PIN_N = 3;
	localparam int SEG_STRIDE = 4;
	localparam int SYNC_STAGES = 2;
	// Word addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_TRIG = 8'h01;
	localparam logic [7:0] A_PIN = 8'h02;
	localparam logic [7:0] A_MASK = 8'h03;
	localparam logic [7:0] A_HI_LO = 8'h04;
	localparam logic [7:0] A_HI_HI = 8'h05;
	localparam logic [7:0] A_LO_LO = 8'h06;
	localparam logic [7:0] A_LO_HI = 8'h07;
	localparam logic [7:0] A_DEV = 8'h08;
	localparam logic [7:0] A_STATUS = 8'h09;
	localparam logic [7:0] A_NUM_LO = 8'h0A;
	localparam logic [7:0] A_NUM_HI = 8'h0B;
	localparam logic [7:0] A_SEG_BASE = 8'h10;
	localparam logic [1:0] SEG_INCR = 2'h0;
	localparam logic [1:0] SEG_COUNT = 2'h1;
	localparam logic [1:0] SEG_CFG = 2'h2;
	// Field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int TRIG_A_LSB = 0;
	localparam int TRIG_B_LSB = 4;
	localparam int KEY_SEL_LSB = 8;
	localparam int MASK0_LSB = 0;
	localparam int MASK1_LSB = 8;
	localparam int CFG_SUCC_LSB = 0;
	localparam int CFG_TRIG_LSB = 4;
	localparam int CFG_CLEAR_BIT = 8;
	localparam int CFG_SLOW_BIT = 9;
	localparam int ST_SEG_LSB = 0;
	localparam int ST_STATE_LSB = 4;
	localparam int ST_FLAG_HI_BIT = 8;
	localparam int ST_FLAG_LO_BIT = 9;
	localparam int ST_KEY_BIT = 10;
	// Encodings
	localparam logic [1:0] NT_TIMEOUT = 2'h0;
	localparam logic [1:0] NT_A = 2'h1;
	localparam logic [1:0] NT_B = 2'h2;
	localparam logic [2:0] SRC_T1_RISE = 3'h1;
	localparam logic [2:0] SRC_T1_FALL = 3'h2;
	localparam logic [2:0] SRC_KEYPIN_RISE = 3'h3;
	localparam logic [2:0] SRC_KEYPIN_FALL = 3'h4;
	localparam logic [2:0] SRC_T2_RISE = 3'h5;
	localparam logic [2:0] SRC_T2_FALL = 3'h6;
	localparam logic [3:0] PIN_INPUT = 4'h7;
	localparam logic [3:0] PIN_FLAG_HI = 4'h8;
	localparam logic [3:0] PIN_FLAG_LO = 4'h9;
	localparam logic [3:0] PIN_SEG_START = 4'hA;
	// Reset values and the count of a segment's last step
	localparam logic [11:0] RST_PIN_CFG = 12'h777;
	localparam logic [32:0] RST_LIMIT = 33'h0_0000_0000;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [15:0] COUNT_LAST = 16'h0001;
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_WAIT} seq_state_t;

	// Event decode shared by both trigger channels
	function automatic logic src_event(
		input logic [SRC_W-1:0] sel,
		input logic [PIN_N-1:0] rise,
		input logic [PIN_N-1:0] fall
	);
		case (sel)
			SRC_T1_RISE: return rise[0];
			SRC_T1_FALL: return fall[0];
			SRC_KEYPIN_RISE: return rise[2];
			SRC_KEYPIN_FALL: return fall[2];
			SRC_T2_RISE: return rise[1];
			SRC_T2_FALL: return fall[1];
			default: return 1'b0;
		endcase
	endfunction

	// Anything but a flag or start code parks the pin low
	function automatic logic pin_drive(
		input logic [PINCFG_W-1:0] c,
		input logic f_hi,
		input logic f_lo,
		input logic s
	);
		case (c)
			PIN_FLAG_HI: return f_hi;
			PIN_FLAG_LO: return f_lo;
			PIN_SEG_START: return s;
			default: return 1'b0;
		endcase
	endfunction
endpackage

// ### pkg/trig_if.sv
// Pin levels in, synchronised edges out
interface trig_if #(parameter int N = 3);
	logic [N-1:0] level;
	logic [N-1:0] rise;
	logic [N-1:0] fall;
	modport sync (input level, output rise, output fall);
	modport user (output level, input rise, input fall);
endinterface

// ### rtl/edge_sync.sv
// Two-flop synchroniser with rise and fall detection per pin
module edge_sync #(
	parameter int N = 3
) (
	input wire logic clock,
	input wire logic nrst,
	trig_if.sync t
);
	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] s3;
		logic [N-1:0] rise;
		logic [N-1:0] fall;
	} sync_t;

	sync_t r, n;

	// First stage feeds only the second
	always_comb
	begin
		n = r;
		n.s1 = t.level;
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.rise = r.s2 & ~r.s3;
		n.fall = ~r.s2 & r.s3;
		if (!nrst)
		begin
			n = '0;
		end
	end

	always_ff @(posedge clock)
	begin
		r <= n;
	end

	assign t.rise = r.rise;
	assign t.fall = r.fall;
endmodule // edge_sync

// ### rtl/ramp_gen.sv
// Segmented ramp sequencer with limit flags, keying and register port
module ramp_gen #(
	parameter int SEGMENTS = 8,
	parameter int ADDR_W = 8,
	parameter int DATA_W = 32
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [DATA_W-1:0] rdata,
	input wire logic first_trigger_pin_in,
	output logic first_trigger_pin_out,
	output logic first_trigger_pin_oe,
	input wire logic second_trigger_pin_in,
	output logic second_trigger_pin_out,
	output logic second_trigger_pin_oe,
	input wire logic keying_input_pin_in,
	output logic keying_input_pin_out,
	output logic keying_input_pin_oe,
	output logic first_comparator_flag,
	output logic second_comparator_flag,
	output logic [ramp_pkg::NUM_W-1:0] freq_numerator,
	output logic [$clog2(SEGMENTS)-1:0] segment_index,
	output logic ramp_active
);
	localparam int SIW = $clog2(SEGMENTS);
	localparam int NW = ramp_pkg::NUM_W;
	localparam int PN = ramp_pkg::PIN_N;
	localparam int PW = ramp_pkg::PINCFG_W;
	localparam logic [ADDR_W-1:0] SEG_SPAN = ADDR_W'(ramp_pkg::SEG_STRIDE * SEGMENTS);

	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic enable;
		logic [ramp_pkg::SRC_W-1:0] first_trigger_source_select;
		logic [ramp_pkg::SRC_W-1:0] second_trigger_source_select;
		logic [1:0] keying_trigger_select;
		logic [PN*PW-1:0] pin_cfg;
		logic [SEGMENTS-1:0] comparator_segment_mask;
		logic [SEGMENTS-1:0] low_segment_mask;
		logic [NW-1:0] lim_hi;
		logic [NW-1:0] lim_lo;
		logic [31:0] key_dev;
		logic [SEGMENTS-1:0][31:0] segment_step_increment;
		logic [SEGMENTS-1:0][ramp_pkg::CNT_W-1:0] segment_step_count;
		logic [SEGMENTS-1:0][SIW-1:0] segment_successor;
		logic [SEGMENTS-1:0][1:0] segment_successor_trigger;
		logic [SEGMENTS-1:0] segment_numerator_clear;
		logic [SEGMENTS-1:0] segment_slow_step;
		ramp_pkg::seq_state_t st;
		logic [SIW-1:0] seg;
		logic [ramp_pkg::CNT_W-1:0] cnt;
		logic half;
		logic [NW-1:0] acc;
		logic key_on;
		logic [NW-1:0] freq;
		logic flag_hi;
		logic flag_lo;
		logic seg_start;
		logic [PN-1:0] pin_out;
		logic [PN-1:0] pin_oe;
		logic active;
	} state_t;

	state_t r, n;

	logic step;
	logic last;
	logic go;
	logic [SIW-1:0] nxt_seg;
	logic [SIW-1:0] succ_cur;
	logic [1:0] ntrig_cur;
	logic [NW-1:0] inc_ext;
	logic [ramp_pkg::CNT_W-1:0] count_go;
	logic clear_go;
	logic evt_a;
	logic evt_b;
	logic key_evt;
	logic [ADDR_W-1:0] seg_off;
	logic [SIW-1:0] seg_sel;
	logic seg_hit;
	logic [DATA_W-1:0] rword;
	logic [PW-1:0] cfg;

	trig_if #(.N(PN)) tr ();

	edge_sync #(.N(PN)) u_sync (
		.clock(clock),
		.nrst(nrst),
		.t(tr)
	);

	// Only pins configured as inputs feed the trigger logic
	assign tr.level[0] = first_trigger_pin_in & (r.pin_cfg[0 +: PW] == ramp_pkg::PIN_INPUT);
	assign tr.level[1] = second_trigger_pin_in & (r.pin_cfg[PW +: PW] == ramp_pkg::PIN_INPUT);
	assign tr.level[2] = keying_input_pin_in & (r.pin_cfg[2*PW +: PW] == ramp_pkg::PIN_INPUT);

	always_comb
	begin
		n = r;
		step = 1'b0;
		last = 1'b0;
		go = 1'b0;
		nxt_seg = '0;
		rword = '0;
		cfg = '0;
		succ_cur = r.segment_successor[r.seg];
		ntrig_cur = r.segment_successor_trigger[r.seg];
		inc_ext = {r.segment_step_increment[r.seg][31], r.segment_step_increment[r.seg]};
		seg_off = addr - ramp_pkg::A_SEG_BASE;
		seg_sel = seg_off[SIW+1:2];
		seg_hit = seg_off < SEG_SPAN;
		evt_a = ramp_pkg::src_event(r.first_trigger_source_select, tr.rise, tr.fall);
		evt_b = ramp_pkg::src_event(r.second_trigger_source_select, tr.rise, tr.fall);
		case (r.keying_trigger_select)
			ramp_pkg::NT_A: key_evt = evt_a;
			ramp_pkg::NT_B: key_evt = evt_b;
			default: key_evt = 1'b0;
		endcase

		if (wr)
		begin
			case (addr)
				ramp_pkg::A_CTRL: n.enable = wdata[ramp_pkg::CTRL_EN_BIT];
				ramp_pkg::A_TRIG:
				begin
					n.first_trigger_source_select = wdata[ramp_pkg::TRIG_A_LSB +: ramp_pkg::SRC_W];
					n.second_trigger_source_select = wdata[ramp_pkg::TRIG_B_LSB +: ramp_pkg::SRC_W];
					n.keying_trigger_select = wdata[ramp_pkg::KEY_SEL_LSB +: 2];
				end
				ramp_pkg::A_PIN: n.pin_cfg = wdata[PN*PW-1:0];
				ramp_pkg::A_MASK:
				begin
					n.comparator_segment_mask = wdata[ramp_pkg::MASK0_LSB +: SEGMENTS];
					n.low_segment_mask = wdata[ramp_pkg::MASK1_LSB +: SEGMENTS];
				end
				ramp_pkg::A_HI_LO: n.lim_hi[31:0] = wdata[31:0];
				ramp_pkg::A_HI_HI: n.lim_hi[32] = wdata[0];
				ramp_pkg::A_LO_LO: n.lim_lo[31:0] = wdata[31:0];
				ramp_pkg::A_LO_HI: n.lim_lo[32] = wdata[0];
				ramp_pkg::A_DEV: n.key_dev = wdata[31:0];
				default:
				begin
					if (seg_hit)
					begin
						case (seg_off[1:0])
							ramp_pkg::SEG_INCR: n.segment_step_increment[seg_sel] = wdata[31:0];
							ramp_pkg::SEG_COUNT: n.segment_step_count[seg_sel] = wdata[ramp_pkg::CNT_W-1:0];
							ramp_pkg::SEG_CFG:
							begin
								n.segment_successor[seg_sel] = wdata[ramp_pkg::CFG_SUCC_LSB +: SIW];
								n.segment_successor_trigger[seg_sel] = wdata[ramp_pkg::CFG_TRIG_LSB +: 2];
								n.segment_numerator_clear[seg_sel] = wdata[ramp_pkg::CFG_CLEAR_BIT];
								n.segment_slow_step[seg_sel] = wdata[ramp_pkg::CFG_SLOW_BIT];
							end
							default: ;
						endcase
					end
				end
			endcase
		end

		case (addr)
			ramp_pkg::A_CTRL: rword[ramp_pkg::CTRL_EN_BIT] = r.enable;
			ramp_pkg::A_TRIG:
			begin
				rword[ramp_pkg::TRIG_A_LSB +: ramp_pkg::SRC_W] = r.first_trigger_source_select;
				rword[ramp_pkg::TRIG_B_LSB +: ramp_pkg::SRC_W] = r.second_trigger_source_select;
				rword[ramp_pkg::KEY_SEL_LSB +: 2] = r.keying_trigger_select;
			end
			ramp_pkg::A_PIN: rword[PN*PW-1:0] = r.pin_cfg;
			ramp_pkg::A_MASK:
			begin
				rword[ramp_pkg::MASK0_LSB +: SEGMENTS] = r.comparator_segment_mask;
				rword[ramp_pkg::MASK1_LSB +: SEGMENTS] = r.low_segment_mask;
			end
			ramp_pkg::A_HI_LO: rword[31:0] = r.lim_hi[31:0];
			ramp_pkg::A_HI_HI: rword[0] = r.lim_hi[32];
			ramp_pkg::A_LO_LO: rword[31:0] = r.lim_lo[31:0];
			ramp_pkg::A_LO_HI: rword[0] = r.lim_lo[32];
			ramp_pkg::A_DEV: rword[31:0] = r.key_dev;
			ramp_pkg::A_STATUS:
			begin
				rword[ramp_pkg::ST_SEG_LSB +: SIW] = r.seg;
				rword[ramp_pkg::ST_STATE_LSB +: 2] = r.st;
				rword[ramp_pkg::ST_FLAG_HI_BIT] = r.flag_hi;
				rword[ramp_pkg::ST_FLAG_LO_BIT] = r.flag_lo;
				rword[ramp_pkg::ST_KEY_BIT] = r.key_on;
			end
			ramp_pkg::A_NUM_LO: rword[31:0] = r.freq[31:0];
			ramp_pkg::A_NUM_HI: rword[0] = r.freq[32];
			default:
			begin
				if (seg_hit)
				begin
					case (seg_off[1:0])
						ramp_pkg::SEG_INCR: rword[31:0] = r.segment_step_increment[seg_sel];
						ramp_pkg::SEG_COUNT: rword[ramp_pkg::CNT_W-1:0] = r.segment_step_count[seg_sel];
						ramp_pkg::SEG_CFG:
						begin
							rword[ramp_pkg::CFG_SUCC_LSB +: SIW] = r.segment_successor[seg_sel];
							rword[ramp_pkg::CFG_TRIG_LSB +: 2] = r.segment_successor_trigger[seg_sel];
							rword[ramp_pkg::CFG_CLEAR_BIT] = r.segment_numerator_clear[seg_sel];
							rword[ramp_pkg::CFG_SLOW_BIT] = r.segment_slow_step[seg_sel];
						end
						default: ;
					endcase
				end
			end
		endcase
		// Read data exists only in the cycle after the strobe
		n.rdata = rd ? rword : '0;

		case (r.st)
			ramp_pkg::ST_IDLE:
			begin
				go = r.enable;
				nxt_seg = '0;
			end
			ramp_pkg::ST_RUN:
			begin
				step = !r.segment_slow_step[r.seg] || r.half;
				n.half = r.segment_slow_step[r.seg] & ~r.half;
				if (step)
				begin
					n.acc = r.acc + inc_ext;
					n.cnt = r.cnt - ramp_pkg::COUNT_LAST;
					last = (r.cnt == ramp_pkg::COUNT_LAST);
				end
				if (last)
				begin
					nxt_seg = succ_cur;
					if (ntrig_cur == ramp_pkg::NT_TIMEOUT)
						go = 1'b1;
					else
						n.st = ramp_pkg::ST_WAIT;
				end
			end
			ramp_pkg::ST_WAIT:
			begin
				nxt_seg = succ_cur;
				case (ntrig_cur)
					ramp_pkg::NT_A: go = evt_a;
					ramp_pkg::NT_B: go = evt_b;
					default: go = evt_a | evt_b;
				endcase
			end
			default: n.st = ramp_pkg::ST_IDLE;
		endcase

		count_go = r.segment_step_count[nxt_seg];
		clear_go = r.segment_numerator_clear[nxt_seg];
		n.seg_start = go;
		if (go)
		begin
			n.st = ramp_pkg::ST_RUN;
			n.seg = nxt_seg;
			n.cnt = count_go;
			n.half = 1'b0;
			if (clear_go)
			begin
				n.acc = '0;
			end
		end

		// Keying rides on top of the ramp, toggled by its own trigger
		if (key_evt)
		begin
			n.key_on = ~r.key_on;
		end
		n.freq = r.acc + (r.key_on ? {r.key_dev[31], r.key_dev} : '0);
		n.flag_hi = (r.st != ramp_pkg::ST_IDLE) && r.comparator_segment_mask[r.seg]
			&& ($signed(r.acc) >= $signed(r.lim_hi));
		n.flag_lo = (r.st != ramp_pkg::ST_IDLE) && r.low_segment_mask[r.seg]
			&& ($signed(r.acc) <= $signed(r.lim_lo));
		for (int i = 0; i < PN; i++)
		begin
			cfg = r.pin_cfg[i*PW +: PW];
			n.pin_oe[i] = (cfg != ramp_pkg::PIN_INPUT);
			n.pin_out[i] = ramp_pkg::pin_drive(cfg, r.flag_hi, r.flag_lo, r.seg_start);
		end

		// Disabled generator parks at the unmodulated carrier
		if (!r.enable)
		begin
			n.st = ramp_pkg::ST_IDLE;
			n.acc = '0;
			n.key_on = 1'b0;
			n.seg_start = 1'b0;
		end
		n.active = (n.st == ramp_pkg::ST_RUN);

		if (!nrst)
		begin
			n = '0;
			n.pin_cfg = ramp_pkg::RST_PIN_CFG;
			n.lim_hi = ramp_pkg::RST_LIMIT;
			n.lim_lo = ramp_pkg::RST_LIMIT;
			n.st = ramp_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge clock)
	begin
		r <= n;
	end

	assign rdata = r.rdata;
	assign first_trigger_pin_out = r.pin_out[0];
	assign first_trigger_pin_oe = r.pin_oe[0];
	assign second_trigger_pin_out = r.pin_out[1];
	assign second_trigger_pin_oe = r.pin_oe[1];
	assign keying_input_pin_out = r.pin_out[2];
	assign keying_input_pin_oe = r.pin_oe[2];
	assign first_comparator_flag = r.flag_hi;
	assign second_comparator_flag = r.flag_lo;
	assign freq_numerator = r.freq;
	assign segment_index = r.seg;
	assign ramp_active = r.active;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	sequence run_step;
		r.enable && r.st == ramp_pkg::ST_RUN && step && !last;
	endsequence

	sequence seg_done_timeout;
		r.enable && last && ntrig_cur == ramp_pkg::NT_TIMEOUT;
	endsequence

	step_add_a: assert property (run_step |=> r.acc == $past(r.acc) + $past(inc_ext))
		else $error("ramp step did not add increment");
	dwell_hold_a: assert property ((inc_ext == '0) and run_step |=> $stable(r.acc))
		else $error("dwell segment moved the numerator");
	// A disable in the idle slot legally stops the second step
	slow_step_a: assert property (run_step ##0 r.segment_slow_step[r.seg] ##1 r.enable |-> !step ##1 step)
		else $error("slow step did not alternate");
	timeout_next_a: assert property (seg_done_timeout |=> r.st == ramp_pkg::ST_RUN && r.seg == $past(succ_cur))
		else $error("timeout successor not started");
	wait_b_a: assert property (r.enable && r.st == ramp_pkg::ST_WAIT && ntrig_cur == ramp_pkg::NT_B && !evt_b
		|=> r.st == ramp_pkg::ST_WAIT)
		else $error("left wait without second trigger");
	clear_start_a: assert property (r.enable && go && clear_go |=> r.acc == '0)
		else $error("numerator not cleared at segment start");
	count_load_a: assert property (r.enable && go |=> r.cnt == $past(count_go) && !r.half)
		else $error("segment count not loaded");
	enable_off_a: assert property (!r.enable |=> r.st == ramp_pkg::ST_IDLE && r.acc == '0 && !r.key_on)
		else $error("disabled generator still active");
	flag_high_a: assert property (r.st != ramp_pkg::ST_IDLE && r.comparator_segment_mask[r.seg]
		&& $signed(r.acc) >= $signed(r.lim_hi) |=> first_comparator_flag)
		else $error("upper flag missing");
	read_late_a: assert property (!rd |=> rdata == '0)
		else $error("read data outside read slot");
endmodule // ramp_gen

// ### verif/trigger_source.sv
// Behavioural far-side trigger source driving the three pin levels
module trigger_source (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [2:0] fire,
	output logic [2:0] level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] hold_r [3];
	// Pulses last three cycles so the two-flop synchroniser cannot miss them
	always_ff @(posedge clock)
	begin
		for (int i = 0; i < 3; i++)
		begin
			if (!nrst)
				hold_r[i] <= 2'h0;
			else if (fire[i])
				hold_r[i] <= 2'h3;
			else if (hold_r[i] != 2'h0)
				hold_r[i] <= hold_r[i] - 2'h1;
		end
	end
	always_comb
	begin
		for (int i = 0; i < 3; i++)
			level[i] = (hold_r[i] != 2'h0);
	end
endmodule // trigger_source

// ### verif/fmcw_ramp_profile_generator_tb_top.sv
// Self-checking bench for the segmented ramp generator
module fmcw_ramp_profile_generator_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, nrst, wr, rd, seen, active;
	logic t1_out, t1_oe, t2_out, t2_oe, k_out, k_oe, flag_hi, flag_lo;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, d, inc;
	logic [2:0] fire, src, pin, seg;
	logic [32:0] num, f0, lim;
	logic [15:0] cnt;
	int n_fail, checked, seed, k, pulses, cyc, c0;

	// Pad level: the block wins while it drives, else the source's level
	assign pin[0] = (t1_oe === 1'b1) ? t1_out : (src[0] === 1'b1);
	assign pin[1] = (t2_oe === 1'b1) ? t2_out : (src[1] === 1'b1);
	assign pin[2] = (k_oe === 1'b1) ? k_out : (src[2] === 1'b1);

	ramp_gen uut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.first_trigger_pin_in(pin[0]), .first_trigger_pin_out(t1_out), .first_trigger_pin_oe(t1_oe),
		.second_trigger_pin_in(pin[1]), .second_trigger_pin_out(t2_out), .second_trigger_pin_oe(t2_oe),
		.keying_input_pin_in(pin[2]), .keying_input_pin_out(k_out), .keying_input_pin_oe(k_oe),
		.first_comparator_flag(flag_hi), .second_comparator_flag(flag_lo), .freq_numerator(num),
		.segment_index(seg), .ramp_active(active));

	trigger_source partner (.clock(clock), .nrst(nrst), .fire(fire), .level(src));

	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	always @(posedge clock)
		cyc <= cyc + 1;

	function automatic logic [31:0] inc_pat(input int s);
		return 32'h5A5A_0000 ^ (32'h0001_1111 * s);
	endfunction

	task chk(input logic [32:0] seen_v, input logic [32:0] exp_v);
		checked++;
		if (seen_v !== exp_v)
		begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
		end
	endtask

	task finish_test;
		$display("n_fail=%0d checked=%0d", n_fail, checked);
		if (n_fail == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task wreg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	task rreg(input logic [7:0] a, output logic [31:0] v);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		@(negedge clock);
		v = rdata;
	endtask

	task seg_cfg(input int s, input logic [31:0] i, input logic [15:0] c, input logic [31:0] cfg);
		wreg(ramp_pkg::A_SEG_BASE + 8'(4 * s), i);
		wreg(ramp_pkg::A_SEG_BASE + 8'(4 * s) + 8'h01, {16'h0000, c});
		wreg(ramp_pkg::A_SEG_BASE + 8'(4 * s) + 8'h02, cfg);
	endtask

	task wait_seg(input logic [2:0] s, input logic act);
		int i;
		for (i = 0; i < 400 && !(seg === s && active === act); i++)
			@(negedge clock);
		if (i == 400)
		begin
			n_fail++;
			finish_test;
		end
	endtask

	task pulse(input int p);
		@(posedge clock);
		fire[p] <= 1'b1;
		@(posedge clock);
		fire[p] <= 1'b0;
	endtask

	initial
	begin
		nrst = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		fire = 3'h0;
		cyc = 0;
		n_fail = 0;
		checked = 0;
		seed = 26;
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		rreg(ramp_pkg::A_PIN, d);
		chk(33'(d), 33'(ramp_pkg::RST_PIN_CFG));
		chk(33'({t1_oe, t2_oe, k_oe}), 33'h0);
		rreg(8'h0F, d);
		chk(33'(d), 33'h0);
		for (k = 0; k < 8; k++)
			wreg(ramp_pkg::A_SEG_BASE + 8'(4 * k), inc_pat(k));
		for (k = 0; k < 8; k++)
		begin
			rreg(ramp_pkg::A_SEG_BASE + 8'(4 * k), d);
			chk(33'(d), 33'(inc_pat(k)));
		end
		// One self-repeating segment without clear: dwell or ramp, normal or slow step
		for (k = 0; k < 4; k++)
		begin
			inc = (k & 1) ? ({17'h0, 15'($random(seed))} | 32'h0000_0001) : 32'h0000_0000;
			cnt = 16'h0003 + {13'h0, 3'($random(seed))};
			lim = 33'(inc) * 33'h0_0000_001E + 33'h0_0000_0001;
			wreg(ramp_pkg::A_CTRL, 32'h0000_0000);
			seg_cfg(0, inc, cnt, (k & 2) ? 32'h0000_0200 : 32'h0000_0000);
			wreg(ramp_pkg::A_PIN, 32'h0000_08A9);
			wreg(ramp_pkg::A_MASK, (k == 3) ? 32'h0000_0202 : 32'h0000_0101);
			wreg(ramp_pkg::A_HI_LO, lim[31:0]);
			wreg(ramp_pkg::A_HI_HI, {31'h0, lim[32]});
			wreg(ramp_pkg::A_LO_LO, (inc == 0) ? 32'h0000_0000 : 32'hFFFF_FFFF);
			wreg(ramp_pkg::A_LO_HI, (inc == 0) ? 32'h0000_0000 : 32'h0000_0001);
			wreg(ramp_pkg::A_CTRL, 32'h0000_0001);
			wait_seg(3'h0, 1'b1);
			@(negedge clock);
			f0 = num;
			pulses = 0;
			repeat (((k & 2) ? 8 : 4) * cnt)
			begin
				@(negedge clock);
				pulses += int'(t2_out === 1'b1);
			end
			chk(num - f0, 33'(inc) * 33'(4 * cnt));
			chk(33'(pulses), 33'h0_0000_0004);
			seen = 1'b0;
			repeat (150)
			begin
				@(negedge clock);
				seen |= (flag_hi === 1'b1);
			end
			chk(33'(seen), 33'(inc != 0 && k != 3));
			chk(33'(flag_lo), 33'(inc == 0 && k != 3));
			chk(33'({k_oe, k_out}), 33'({1'b1, 1'(inc != 0 && k != 3)}));
			chk(33'({t1_oe, t1_out}), 33'({1'b1, 1'(inc == 0 && k != 3)}));
		end
		// Keying on top of a running ramp, started by a keying pin edge
		wreg(ramp_pkg::A_CTRL, 32'h0000_0000);
		inc = 32'h0000_0100 + {24'h0, 8'($random(seed))};
		seg_cfg(0, inc, 16'h0010, 32'h0000_0000);
		wreg(ramp_pkg::A_PIN, 32'h0000_0777);
		wreg(ramp_pkg::A_TRIG, 32'h0000_0103);
		wreg(ramp_pkg::A_DEV, 32'h0001_0000);
		wreg(ramp_pkg::A_CTRL, 32'h0000_0001);
		wait_seg(3'h0, 1'b1);
		@(negedge clock);
		f0 = num;
		c0 = cyc;
		pulse(2);
		repeat (12) @(negedge clock);
		chk(num - f0, 33'(inc) * 33'(cyc - c0) + 33'h0_0001_0000);
		// Dwell waiting on the second channel, then ramp, then clear
		wreg(ramp_pkg::A_CTRL, 32'h0000_0000);
		seg_cfg(0, 32'h0000_0000, 16'h0002, 32'h0000_0121);
		seg_cfg(1, inc, 16'h0008, 32'h0000_0000);
		wreg(ramp_pkg::A_TRIG, 32'h0000_0010);
		wreg(ramp_pkg::A_CTRL, 32'h0000_0001);
		repeat (10) @(negedge clock);
		rreg(ramp_pkg::A_STATUS, d);
		chk(33'(d[5:4]), 33'h0_0000_0002);
		chk(33'(active), 33'h0);
		pulse(0);
		wait_seg(3'h1, 1'b1);
		chk(33'(seg), 33'h0_0000_0001);
		wait_seg(3'h0, 1'b0);
		repeat (3) @(negedge clock);
		chk(num, 33'h0_0000_0000);
		finish_test;
	end
endmodule // fmcw_ramp_profile_generator_tb_top
